// *** rtl/slse_pkg.sv ***
/*
  Package for the serial link status and error register bank: word slots,
  field positions, status codes and error bit positions.
  Assumes a single clock domain and an AHB-Lite register port.
*/
package slse_pkg;

  // ----------------------------------------
  // slot map (word index, byte address = 4*index)
  // ----------------------------------------
  localparam int unsigned NUM_SLOTS = 16;
  localparam logic [5:0] IDX_STATE = 6'h00;
  localparam logic [5:0] IDX_ERROR = 6'h01;
  localparam logic [5:0] IDX_CTRL = 6'h02;
  localparam logic [31:0] BANK_BYTES = 32'h0000_0040;

  // ----------------------------------------
  // interface state field positions
  // ----------------------------------------
  localparam int unsigned PRES_LSB = 0;
  localparam int unsigned RATE_LSB = 4;
  localparam int unsigned PWR_LSB = 8;

  // ----------------------------------------
  // field codes
  // ----------------------------------------
  localparam logic [3:0] PRES_NONE = 4'h0;
  localparam logic [3:0] PRES_NO_COMM = 4'h1;
  localparam logic [3:0] PRES_COMM = 4'h3;
  localparam logic [3:0] PRES_OFFLINE = 4'h4;
  localparam logic [3:0] RATE_NONE = 4'h0;
  localparam logic [3:0] RATE_GEN1 = 4'h1;
  localparam logic [3:0] PWR_NONE = 4'h0;
  localparam logic [3:0] PWR_ACTIVE = 4'h1;
  localparam logic [3:0] PWR_PARTIAL = 4'h2;
  localparam logic [3:0] PWR_SLUMBER = 4'h6;

  // ----------------------------------------
  // error accumulator bit positions
  // ----------------------------------------
  localparam int unsigned ERR_REC_INTEG = 0;
  localparam int unsigned ERR_REC_COMM = 1;
  localparam int unsigned ERR_TRANSIENT = 8;
  localparam int unsigned ERR_PERSIST = 9;
  localparam int unsigned ERR_PROTOCOL = 10;
  localparam int unsigned ERR_INTERNAL = 11;
  localparam int unsigned DG_PHY_UP_CHG = 16;
  localparam int unsigned DG_PHY_INT = 17;
  localparam int unsigned DG_WAKE = 18;
  localparam int unsigned DG_DECODE = 19;
  localparam int unsigned DG_DISPARITY = 20;
  localparam int unsigned DG_CRC = 21;
  localparam int unsigned DG_HANDSHAKE = 22;
  localparam int unsigned DG_LINK_SEQ = 23;
  localparam int unsigned DG_TRANS_STATE = 24;
  localparam int unsigned DG_UNK_FRAME = 25;
  localparam logic [31:0] ERR_IMPL_MASK = 32'h03ff_0f03;
  localparam logic [31:0] ERR_RESET = 32'h0000_0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    AHB_IDLE = 2'b00,
    AHB_BUSY = 2'b01,
    AHB_NONSEQ = 2'b10,
    AHB_SEQ = 2'b11
  } slse_htrans_t;

  // live condition from phy and power logic
  typedef struct packed
  {
    logic [3:0] presence;
    logic [3:0] rate;
    logic [3:0] power;
  } slse_live_t;

  // one-cycle event indications from phy, link and transport
  typedef struct packed
  {
    logic rec_integ;
    logic rec_comm;
    logic transient;
    logic persist;
    logic protocol;
    logic internal;
    logic phy_int;
    logic wake;
    logic decode;
    logic disparity;
    logic crc;
    logic handshake;
    logic link_seq;
    logic trans_state;
    logic unk_frame;
  } slse_events_t;

endpackage

// *** rtl/slse_regs.sv ***
/*
  Serial link status and error register bank, AHB-Lite slave.
  Assumes live state and events come synchronous to mclk from the
  phy, link and transport logic; the control slot lives elsewhere.
*/
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps

module slse_regs
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire slse_pkg::slse_live_t live_state,
  input wire slse_pkg::slse_events_t err_events,
  input wire logic phy_up_signal,
  input wire logic phy_down_signal,
  input wire logic [31:0] ctrl_rdata,
  output logic ctrl_wr,
  output logic [31:0] ctrl_wdata
);

  // ----------------------------------------
  // address phase capture
  // ----------------------------------------
  logic wr_pend_q;
  logic [3:0] wr_idx_q;
  logic [3:0] rd_idx;
  logic addr_valid;
  logic in_bank;
  logic [31:0] state_word;
  logic [31:0] err_q;
  logic [31:0] err_set;
  logic [31:0] err_clr;
  logic phy_up_q;
  logic phy_down_q;
  logic [31:0] rd_d;

  // only word aligned addresses inside the 16-word window hit the bank
  assign in_bank = (haddr < slse_pkg::BANK_BYTES) && (haddr[1:0] == 2'b00);
  assign addr_valid = hsel && hready && htrans[1] && in_bank;
  assign rd_idx = haddr[5:2];

  // zero wait states: every data phase completes in one cycle
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 4'h0;
    end
    else
    begin
      wr_pend_q <= addr_valid && hwrite;
      wr_idx_q <= rd_idx;
    end
  end

  // ----------------------------------------
  // live interface state
  // ----------------------------------------
  // no storage: the word is built from live inputs when read
  always_comb
  begin
    state_word = 32'h0000_0000;
    state_word[slse_pkg::PRES_LSB +: 4] = live_state.presence;
    state_word[slse_pkg::RATE_LSB +: 4] = live_state.rate;
    state_word[slse_pkg::PWR_LSB +: 4] = live_state.power;
  end

  // ----------------------------------------
  // error accumulator
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      phy_up_q <= 1'b0;
      phy_down_q <= 1'b0;
    end
    else
    begin
      phy_up_q <= phy_up_signal;
      phy_down_q <= phy_down_signal;
    end
  end

  always_comb
  begin
    err_set = 32'h0000_0000;
    err_set[slse_pkg::ERR_PERSIST] = err_events.persist;
    err_set[slse_pkg::ERR_INTERNAL] = err_events.internal;
    err_set[slse_pkg::ERR_REC_INTEG] = err_events.rec_integ;
    // a phy-down episode that ends counts as a recovered loss
    err_set[slse_pkg::ERR_REC_COMM] = err_events.rec_comm | (phy_down_q & ~phy_down_signal);
    err_set[slse_pkg::ERR_PROTOCOL] = err_events.protocol;
    err_set[slse_pkg::ERR_TRANSIENT] = err_events.transient;
    err_set[slse_pkg::DG_DECODE] = err_events.decode;
    err_set[slse_pkg::DG_DISPARITY] = err_events.disparity;
    err_set[slse_pkg::DG_CRC] = err_events.crc;
    err_set[slse_pkg::DG_HANDSHAKE] = err_events.handshake;
    err_set[slse_pkg::DG_UNK_FRAME] = err_events.unk_frame;
    err_set[slse_pkg::DG_PHY_UP_CHG] = phy_up_q ^ phy_up_signal;
    err_set[slse_pkg::DG_WAKE] = err_events.wake;
    err_set[slse_pkg::DG_PHY_INT] = err_events.phy_int;
    err_set[slse_pkg::DG_LINK_SEQ] = err_events.link_seq;
    err_set[slse_pkg::DG_TRANS_STATE] = err_events.trans_state;
  end

  // write-one-to-clear; only the accumulator slot clears
  assign err_clr = (wr_pend_q && (wr_idx_q == slse_pkg::IDX_ERROR[3:0])) ? hwdata
                                                                          : 32'h0000_0000;

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      err_q <= slse_pkg::ERR_RESET;
    else
      // set applied after clear so a coincident event wins
      err_q <= ((err_q & ~err_clr) | err_set) & slse_pkg::ERR_IMPL_MASK;
  end

  // ----------------------------------------
  // control slot pass-through
  // ----------------------------------------
  assign ctrl_wr = wr_pend_q && (wr_idx_q == slse_pkg::IDX_CTRL[3:0]);
  assign ctrl_wdata = hwdata;

  // ----------------------------------------
  // read data
  // ----------------------------------------
  // sampled at the address phase so data stands in the next cycle
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (addr_valid && !hwrite)
    begin
      case (rd_idx)
        slse_pkg::IDX_STATE[3:0]: rd_d = state_word;
        slse_pkg::IDX_ERROR[3:0]: rd_d = err_q;
        slse_pkg::IDX_CTRL[3:0]: rd_d = ctrl_rdata;
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= rd_d;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_sticky;
    @(posedge mclk) disable iff (sys_rst)
    (err_q[slse_pkg::ERR_PERSIST] && !err_clr[slse_pkg::ERR_PERSIST])
      |=> err_q[slse_pkg::ERR_PERSIST];
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky bit dropped");

  property p_w1c;
    @(posedge mclk) disable iff (sys_rst)
    (wr_pend_q && wr_idx_q == 4'h1 && hwdata[slse_pkg::DG_CRC] && !err_events.crc)
      |=> !err_q[slse_pkg::DG_CRC];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_set_wins;
    @(posedge mclk) disable iff (sys_rst)
    (err_clr[slse_pkg::ERR_PROTOCOL] && err_events.protocol) |=> err_q[slse_pkg::ERR_PROTOCOL];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("event lost to clear");

  property p_reset_clear;
    @(posedge mclk) sys_rst |=> (err_q == 32'h0000_0000);
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset left errors");

  property p_reserved_zero;
    @(posedge mclk) disable iff (sys_rst)
    (err_q & ~slse_pkg::ERR_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  property p_state_read;
    @(posedge mclk) disable iff (sys_rst)
    (addr_valid && !hwrite && rd_idx == 4'h0)
      |=> (hrdata == {20'h00000, $past(live_state.power), $past(live_state.rate),
                      $past(live_state.presence)});
  endproperty
  a_state_read: assert property (p_state_read) else $error("state read mismatch");

  property p_rsvd_read;
    @(posedge mclk) disable iff (sys_rst)
    (addr_valid && !hwrite && rd_idx > 4'h2) |=> (hrdata == 32'h0000_0000);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved slot nonzero");

  property p_phy_toggle;
    @(posedge mclk) disable iff (sys_rst)
    (phy_up_q != phy_up_signal) |=> err_q[slse_pkg::DG_PHY_UP_CHG];
  endproperty
  a_phy_toggle: assert property (p_phy_toggle) else $error("phy change missed");

  property p_state_wr;
    @(posedge mclk) disable iff (sys_rst)
    (wr_pend_q && wr_idx_q == 4'h0) |-> (err_clr == 32'h0000_0000) && !ctrl_wr;
  endproperty
  a_state_wr: assert property (p_state_wr) else $error("state write had effect");

  // ----------------------------------------
  // checks: event set paths
  // ----------------------------------------
  // each event must show in the accumulator one edge later
  property p_ev_persist;
    @(posedge mclk) disable iff (sys_rst)
    err_events.persist |=> err_q[slse_pkg::ERR_PERSIST];
  endproperty
  a_ev_persist: assert property (p_ev_persist) else $error("persist flag missed");

  property p_ev_internal;
    @(posedge mclk) disable iff (sys_rst)
    err_events.internal |=> err_q[slse_pkg::ERR_INTERNAL];
  endproperty
  a_ev_internal: assert property (p_ev_internal) else $error("internal flag missed");

  property p_ev_rec_integ;
    @(posedge mclk) disable iff (sys_rst)
    err_events.rec_integ |=> err_q[slse_pkg::ERR_REC_INTEG];
  endproperty
  a_ev_rec_integ: assert property (p_ev_rec_integ) else $error("integrity flag missed");

  property p_ev_rec_comm;
    @(posedge mclk) disable iff (sys_rst)
    err_events.rec_comm |=> err_q[slse_pkg::ERR_REC_COMM];
  endproperty
  a_ev_rec_comm: assert property (p_ev_rec_comm) else $error("comm flag missed");

  property p_phy_down_end;
    @(posedge mclk) disable iff (sys_rst)
    (phy_down_q && !phy_down_signal) |=> err_q[slse_pkg::ERR_REC_COMM];
  endproperty
  a_phy_down_end: assert property (p_phy_down_end) else $error("regained link missed");

  property p_ev_protocol;
    @(posedge mclk) disable iff (sys_rst)
    err_events.protocol |=> err_q[slse_pkg::ERR_PROTOCOL];
  endproperty
  a_ev_protocol: assert property (p_ev_protocol) else $error("protocol flag missed");

  property p_ev_transient;
    @(posedge mclk) disable iff (sys_rst)
    err_events.transient |=> err_q[slse_pkg::ERR_TRANSIENT];
  endproperty
  a_ev_transient: assert property (p_ev_transient) else $error("transient flag missed");

  property p_ev_decode;
    @(posedge mclk) disable iff (sys_rst)
    err_events.decode |=> err_q[slse_pkg::DG_DECODE];
  endproperty
  a_ev_decode: assert property (p_ev_decode) else $error("decode flag missed");

  property p_ev_disparity;
    @(posedge mclk) disable iff (sys_rst)
    err_events.disparity |=> err_q[slse_pkg::DG_DISPARITY];
  endproperty
  a_ev_disparity: assert property (p_ev_disparity) else $error("disparity flag missed");

  property p_ev_crc;
    @(posedge mclk) disable iff (sys_rst)
    err_events.crc |=> err_q[slse_pkg::DG_CRC];
  endproperty
  a_ev_crc: assert property (p_ev_crc) else $error("crc flag missed");

  property p_ev_handshake;
    @(posedge mclk) disable iff (sys_rst)
    err_events.handshake |=> err_q[slse_pkg::DG_HANDSHAKE];
  endproperty
  a_ev_handshake: assert property (p_ev_handshake) else $error("handshake flag missed");

  property p_ev_unk_frame;
    @(posedge mclk) disable iff (sys_rst)
    err_events.unk_frame |=> err_q[slse_pkg::DG_UNK_FRAME];
  endproperty
  a_ev_unk_frame: assert property (p_ev_unk_frame) else $error("frame type flag missed");

  property p_ev_wake;
    @(posedge mclk) disable iff (sys_rst)
    err_events.wake |=> err_q[slse_pkg::DG_WAKE];
  endproperty
  a_ev_wake: assert property (p_ev_wake) else $error("wake flag missed");

  property p_ev_phy_int;
    @(posedge mclk) disable iff (sys_rst)
    err_events.phy_int |=> err_q[slse_pkg::DG_PHY_INT];
  endproperty
  a_ev_phy_int: assert property (p_ev_phy_int) else $error("phy internal flag missed");

  property p_ev_link_seq;
    @(posedge mclk) disable iff (sys_rst)
    err_events.link_seq |=> err_q[slse_pkg::DG_LINK_SEQ];
  endproperty
  a_ev_link_seq: assert property (p_ev_link_seq) else $error("link sequence flag missed");

  property p_ev_trans_state;
    @(posedge mclk) disable iff (sys_rst)
    err_events.trans_state |=> err_q[slse_pkg::DG_TRANS_STATE];
  endproperty
  a_ev_trans_state: assert property (p_ev_trans_state) else $error("transport flag missed");

  // ----------------------------------------
  // checks: bus side
  // ----------------------------------------
  property p_err_read;
    @(posedge mclk) disable iff (sys_rst)
    (addr_valid && !hwrite && rd_idx == 4'h1)
      |=> (hrdata == $past(err_q));
  endproperty
  a_err_read: assert property (p_err_read) else $error("error read mismatch");

  property p_ctrl_wr;
    @(posedge mclk) disable iff (sys_rst)
    (addr_valid && hwrite && rd_idx == 4'h2) |=> ctrl_wr;
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_okay;
    @(posedge mclk) disable iff (sys_rst)
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus response not okay");

  property p_outside_read;
    @(posedge mclk) disable iff (sys_rst)
    (hsel && hready && htrans[1] && !hwrite && !in_bank) |=> (hrdata == 32'h0000_0000);
  endproperty
  a_outside_read: assert property (p_outside_read) else $error("outside read nonzero");

  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_clear: cover property (@(posedge mclk) err_q[slse_pkg::DG_CRC] ##1 !err_q[slse_pkg::DG_CRC]);
  c_read_err: cover property (@(posedge mclk) addr_valid && !hwrite && rd_idx == 4'h1);
  c_coincide: cover property (@(posedge mclk) err_clr[slse_pkg::ERR_PROTOCOL] && err_events.protocol);
  c_phy_change: cover property (@(posedge mclk) phy_up_q != phy_up_signal);
  c_state_write: cover property (@(posedge mclk) wr_pend_q && wr_idx_q == 4'h0);

endmodule

// *** verification/slse_far_model.sv ***
/*
  Far-side model: phy, link and transport logic feeding live state,
  error events and phy levels, plus the external control slot.
  Assumes the bench sets its requests just after rising mclk edges.
*/
`timescale 1ns/10ps

module slse_far_model
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire slse_pkg::slse_live_t live_req,
  input wire slse_pkg::slse_events_t ev_req,
  input wire logic up_req,
  input wire logic down_req,
  input wire logic ctrl_wr,
  input wire logic [31:0] ctrl_wdata,
  output slse_pkg::slse_live_t live_state,
  output slse_pkg::slse_events_t err_events,
  output logic phy_up_signal,
  output logic phy_down_signal,
  output logic [31:0] ctrl_rdata
);
  // ----------------------------------------
  // levels and one-cycle events
  // ----------------------------------------
  assign live_state = live_req;
  assign err_events = ev_req;
  assign phy_up_signal = up_req;
  // falling edge here marks regained comms
  assign phy_down_signal = down_req;

  // ----------------------------------------
  // control slot keeps the last word written
  // ----------------------------------------
  always_ff @(posedge mclk)
  begin
    if (sys_rst)
      ctrl_rdata <= 32'h0000_0000;
    else if (ctrl_wr)
      ctrl_rdata <= ctrl_wdata;
  end
endmodule

// *** verification/serial_link_status_error_regs_tb.sv ***
/*
  Self-checking bench for the status and error register bank.
  Assumes slse_regs and slse_far_model; zero-wait AHB-Lite slave.
*/
`timescale 1ns/10ps

module serial_link_status_error_regs_tb;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  slse_pkg::slse_live_t live_req = '0;
  slse_pkg::slse_events_t ev_req = '0;
  logic up_req = 1'b0;
  logic down_req = 1'b0;
  slse_pkg::slse_live_t live_state;
  slse_pkg::slse_events_t err_events;
  logic phy_up_signal;
  logic phy_down_signal;
  logic [31:0] ctrl_rdata;
  logic [31:0] ctrl_wdata;
  logic ctrl_wr;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int ev_pos [15] = '{0, 1, 8, 9, 10, 11, 17, 18, 19, 20, 21, 22, 23, 24, 25};
  logic [3:0] pres_c [4] = '{4'h0, 4'h1, 4'h3, 4'h4};
  logic [3:0] pwr_c [4] = '{4'h0, 4'h1, 4'h2, 4'h6};

  always #50 mclk = ~mclk;

  slse_regs i_dut
  (
    .mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .live_state(live_state), .err_events(err_events), .phy_up_signal(phy_up_signal),
    .phy_down_signal(phy_down_signal), .ctrl_rdata(ctrl_rdata), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata)
  );

  slse_far_model i_far
  (
    .mclk(mclk), .sys_rst(sys_rst), .live_req(live_req), .ev_req(ev_req),
    .up_req(up_req), .down_req(down_req), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
    .live_state(live_state), .err_events(err_events), .phy_up_signal(phy_up_signal),
    .phy_down_signal(phy_down_signal), .ctrl_rdata(ctrl_rdata)
  );

  // ----------------------------------------
  // bus cycles and comparison
  // ----------------------------------------
  task automatic summarize;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // events passed in ev land in the data phase, racing the clear
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
    input slse_pkg::slse_events_t ev, output logic [31:0] rdv);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= slse_pkg::AHB_NONSEQ;
    hwrite <= w;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= slse_pkg::AHB_IDLE;
    hwdata <= wd;
    ev_req <= ev;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    rdv = hrdata;
    ev_req <= '0;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, '0, x);
  endtask

  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, '0, x);
    check(n, x, e);
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask

  task automatic pulse(input slse_pkg::slse_events_t v);
    @(posedge mclk);
    ev_req <= v;
    @(posedge mclk);
    ev_req <= '0;
  endtask

  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    slse_pkg::slse_events_t one;
    logic [31:0] x;
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    rchk("err_reset", 32'h4, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge mclk);
      live_req <= '{pres_c[i], 4'(i % 2), pwr_c[i]};
      rchk("state", 32'h0, {20'h0, pwr_c[i], 4'(i % 2), pres_c[i]});
    end
    wr(32'h0, 32'hffff_ffff);
    rchk("state_ro", 32'h0, 32'h0000_0614);
    for (int i = 0; i < 15; i++)
    begin
      one = '0;
      one[14 - i] = 1'b1;
      pulse(one);
      rchk("err_bit", 32'h4, 32'h1 << ev_pos[i]);
      wr(32'h4, 32'h1 << ev_pos[i]);
      rchk("err_clr", 32'h4, 32'h0);
    end
    pulse('1);
    rchk("err_all", 32'h4, 32'h03fe_0f03);
    wr(32'h4, 32'h0000_0f00);
    rchk("err_w1c", 32'h4, 32'h03fe_0003);
    wr(32'h4, 32'h0);
    rchk("err_w0", 32'h4, 32'h03fe_0003);
    ahb(1'b1, 32'h4, 32'h0000_0003, 15'h4000, x);
    rchk("err_race", 32'h4, 32'h03fe_0001);
    @(posedge mclk);
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    rchk("err_rst", 32'h4, 32'h0);
    @(posedge mclk);
    up_req <= 1'b1;
    rchk("phy_up", 32'h4, 32'h0001_0000);
    wr(32'h4, 32'h0001_0000);
    @(posedge mclk);
    down_req <= 1'b1;
    rchk("phy_dn_rise", 32'h4, 32'h0);
    @(posedge mclk);
    down_req <= 1'b0;
    rchk("phy_dn_fall", 32'h4, 32'h0000_0002);
    wr(32'h8, 32'h0000_0301);
    rchk("ctrl", 32'h8, 32'h0000_0301);
    for (int s = 3; s < 16; s++)
    begin
      wr(32'(s * 4), 32'hffff_ffff);
      rchk("reserved", 32'(s * 4), 32'h0);
    end
    rchk("outside", 32'h40, 32'h0);
    rchk("err_kept", 32'h4, 32'h0000_0002);
    summarize();
  end
endmodule
